// File: hw/ipd_cfg.svh
`ifndef IPD_CFG_SVH
`define IPD_CFG_SVH
`define IPD_AW 22
`define IPD_DW 16
`define IPD_REG_CNT 4
`define IPD_BASE 16'hff40
`define IPD_STATUS_IDX 2'h3
`define IPD_REG_RST 16'h0000
`define IPD_CLK_NS 5
`define IPD_TIMEOUT_NS 10000
`define IPD_TIMEOUT_CYC (`IPD_TIMEOUT_NS / `IPD_CLK_NS)
`define IPD_PAGE16_HI 3'h7
`define IPD_PAGE18_HI 5'h1f
`define IPD_PAGE22_HI 9'h1ff
`endif

// File: hw/ipd_pkg.sv
package ipd_pkg;
  typedef enum logic [1:0] {
    IPD_MODE_16 = 2'b00,
    IPD_MODE_18 = 2'b01,
    IPD_MODE_22 = 2'b10
  } ipd_mode_t;
  typedef enum logic [1:0] {
    IPD_IDLE = 2'b00,
    IPD_ADDR = 2'b01,
    IPD_DATA = 2'b10
  } ipd_state_t;
endpackage : ipd_pkg

// File: hw/ipd_bus_if.sv
`include "ipd_cfg.svh"
interface ipd_bus_if;
  logic [`IPD_AW-1:0] mst_adl_out;
  logic mst_adl_oe;
  logic [`IPD_DW-1:0] dev_adl_out;
  logic dev_adl_oe;
  logic [`IPD_AW-1:0] shared_addr_data_lines;
  logic io_page_select_n;
  logic addr_strobe;
  logic data_strobe;
  logic write;
  logic byte_xfer;
  logic reply;
  logic bus_req;
  logic grant;
  logic grant_out;
  // Wire level of the shared lines; undriven lines read low
  assign shared_addr_data_lines = dev_adl_oe ? {{(`IPD_AW-`IPD_DW){1'b0}}, dev_adl_out} :
                                  mst_adl_oe ? mst_adl_out : '0;
  modport master (
    output mst_adl_out, mst_adl_oe, io_page_select_n, addr_strobe, data_strobe, write,
    output byte_xfer, grant,
    input shared_addr_data_lines, reply, bus_req
  );
  modport device (
    output dev_adl_out, dev_adl_oe, reply, bus_req, grant_out,
    input shared_addr_data_lines, io_page_select_n, addr_strobe, data_strobe, write,
    input byte_xfer, grant
  );
endinterface : ipd_bus_if

// File: hw/ipd_device.sv
`include "ipd_cfg.svh"
module ipd_device (
  input wire logic CLK,
  input wire logic RST_N,
  ipd_bus_if.device BUS,
  input wire logic SERVICE_REQ,
  input wire logic [`IPD_DW-1:0] STATUS_IN,
  output logic [`IPD_DW-1:0] CTRL_OUT,
  output logic SERVICE_GRANTED,
  output logic SELECTED
);
  logic sel;
  logic next_sel;
  logic [1:0] idx;
  logic [1:0] next_idx;
  logic odd;
  logic next_odd;
  logic reply;
  logic next_reply;
  logic [`IPD_DW-1:0] dout;
  logic [`IPD_DW-1:0] next_dout;
  logic oe;
  logic next_oe;
  logic req;
  logic next_req;
  logic granted;
  logic next_granted;
  logic gout;
  logic next_gout;
  logic [`IPD_DW-1:0] regs [`IPD_REG_CNT];
  logic wr_take;
  logic [`IPD_DW-1:0] lines;
  logic sreq_meta;
  logic next_sreq_meta;
  logic sreq_sync;
  logic next_sreq_sync;
  logic [`IPD_DW-1:0] status_meta;
  logic [`IPD_DW-1:0] next_status_meta;
  logic [`IPD_DW-1:0] status_sync;
  logic [`IPD_DW-1:0] next_status_sync;
  logic addr_match;
  logic page_sel;
  logic [`IPD_DW-1:0] rd_word;

  assign lines = BUS.shared_addr_data_lines[`IPD_DW-1:0];
  assign wr_take = BUS.data_strobe && sel && !reply && BUS.write;
  // Page select alone marks an I/O page access
  assign page_sel = !BUS.io_page_select_n;
  assign addr_match = lines[15:3] == 13'(`IPD_BASE >> 3);
  // Status index reads the synchronised pin word
  assign rd_word = (idx == `IPD_STATUS_IDX) ? status_sync : regs[idx];

  // Address phase decode and data phase answer
  always_comb
  begin
    next_sel = sel;
    next_idx = idx;
    next_odd = odd;
    next_reply = 1'b0;
    next_oe = 1'b0;
    next_dout = dout;
    if (BUS.addr_strobe)
    begin
      // Only low 16 bits are compared; bits above 15 are ignored
      next_sel = page_sel && addr_match;
      next_idx = lines[2:1];
      next_odd = lines[0];
    end
    else if (BUS.data_strobe && sel && !reply)
    begin
      next_reply = 1'b1;
      if (!BUS.write)
      begin
        next_oe = 1'b1;
        next_dout = rd_word;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sel <= 1'b0;
      idx <= 2'h0;
      odd <= 1'b0;
      reply <= 1'b0;
      oe <= 1'b0;
      dout <= 16'h0000;
    end
    else
    begin
      sel <= next_sel;
      idx <= next_idx;
      odd <= next_odd;
      reply <= next_reply;
      oe <= next_oe;
      dout <= next_dout;
    end
  end

  // Writable registers with byte lanes; the status index is read-only
  genvar g;
  generate
    for (g = 0; g < `IPD_REG_CNT; g++)
    begin : g_reg
      logic [`IPD_DW-1:0] next_reg;
      always_comb
      begin
        next_reg = regs[g];
        if (wr_take && idx == 2'(g) && 2'(g) != `IPD_STATUS_IDX)
        begin
          if (!BUS.byte_xfer)
            next_reg = lines;
          else if (odd)
            next_reg[15:8] = lines[15:8];
          else
            next_reg[7:0] = lines[7:0];
        end
      end
      always_ff @(posedge CLK or negedge RST_N)
      begin
        if (!RST_N)
          regs[g] <= `IPD_REG_RST;
        else
          regs[g] <= next_reg;
      end
    end
  endgenerate

  // Two-stage synchronisers for the pin inputs
  always_comb
  begin
    next_sreq_meta = SERVICE_REQ;
    next_sreq_sync = sreq_meta;
    next_status_meta = STATUS_IN;
    next_status_sync = status_meta;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sreq_meta <= 1'b0;
      sreq_sync <= 1'b0;
      status_meta <= 16'h0000;
      status_sync <= 16'h0000;
    end
    else
    begin
      sreq_meta <= next_sreq_meta;
      sreq_sync <= next_sreq_sync;
      status_meta <= next_status_meta;
      status_sync <= next_status_sync;
    end
  end

  // Grant chain: the nearer device takes the grant, else passes it on
  always_comb
  begin
    next_req = sreq_sync && !granted;
    next_granted = 1'b0;
    next_gout = 1'b0;
    if (BUS.grant)
    begin
      if (sreq_sync)
        next_granted = 1'b1;
      else
        next_gout = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      req <= 1'b0;
      granted <= 1'b0;
      gout <= 1'b0;
    end
    else
    begin
      req <= next_req;
      granted <= next_granted;
      gout <= next_gout;
    end
  end

  assign BUS.dev_adl_out = dout;
  assign BUS.dev_adl_oe = oe;
  assign BUS.reply = reply;
  assign BUS.bus_req = req;
  assign BUS.grant_out = gout;
  assign CTRL_OUT = regs[0];
  assign SERVICE_GRANTED = granted;
  assign SELECTED = sel;
endmodule : ipd_device

// File: hw/ipd_master.sv
`include "ipd_cfg.svh"
module ipd_master (
  input wire logic CLK,
  input wire logic RST_N,
  ipd_bus_if.master BUS,
  input wire logic START,
  input wire logic [`IPD_AW-1:0] ADDR,
  input wire logic WRITE,
  input wire logic BYTE,
  input wire logic [`IPD_DW-1:0] WDATA,
  input wire logic [1:0] ADDR_MODE,
  output logic BUSY,
  output logic DONE,
  output logic TIMEOUT,
  output logic [`IPD_DW-1:0] RDATA
);
  ipd_pkg::ipd_state_t st;
  ipd_pkg::ipd_state_t next_st;
  logic [`IPD_AW-1:0] aout;
  logic [`IPD_AW-1:0] next_aout;
  logic aoe;
  logic next_aoe;
  logic sel_n;
  logic next_sel_n;
  logic astb;
  logic next_astb;
  logic dstb;
  logic next_dstb;
  logic wr;
  logic next_wr;
  logic bx;
  logic next_bx;
  logic odd;
  logic next_odd;
  logic [`IPD_DW-1:0] wd;
  logic [`IPD_DW-1:0] next_wd;
  logic [11:0] cnt;
  logic [11:0] next_cnt;
  logic busy;
  logic next_busy;
  logic done;
  logic next_done;
  logic tmo;
  logic next_tmo;
  logic [`IPD_DW-1:0] rd;
  logic [`IPD_DW-1:0] next_rd;
  logic gnt;
  logic next_gnt;
  logic [`IPD_AW-1:0] amask;
  logic page_hit;
  logic [`IPD_DW-1:0] rword;

  // Address limited to the configured width; page is its top 8K
  always_comb
  begin
    unique case (ADDR_MODE)
      ipd_pkg::IPD_MODE_16:
      begin
        amask = {6'h00, ADDR[15:0]};
        page_hit = ADDR[15:13] == `IPD_PAGE16_HI;
      end
      ipd_pkg::IPD_MODE_18:
      begin
        amask = {4'h0, ADDR[17:0]};
        page_hit = ADDR[17:13] == `IPD_PAGE18_HI;
      end
      default:
      begin
        amask = ADDR;
        page_hit = ADDR[21:13] == `IPD_PAGE22_HI;
      end
    endcase
  end

  assign rword = BUS.shared_addr_data_lines[`IPD_DW-1:0];

  always_comb
  begin
    next_st = st;
    next_aout = aout;
    next_aoe = aoe;
    next_sel_n = sel_n;
    next_astb = 1'b0;
    next_dstb = dstb;
    next_wr = wr;
    next_bx = bx;
    next_odd = odd;
    next_wd = wd;
    next_cnt = cnt;
    next_busy = busy;
    next_done = 1'b0;
    next_tmo = 1'b0;
    next_rd = rd;
    next_gnt = BUS.bus_req && !gnt && st == ipd_pkg::IPD_IDLE;
    unique case (st)
      ipd_pkg::IPD_IDLE:
      begin
        if (START)
        begin
          next_st = ipd_pkg::IPD_ADDR;
          next_aout = amask;
          next_aoe = 1'b1;
          next_sel_n = !page_hit;
          next_astb = 1'b1;
          next_wr = WRITE;
          next_bx = BYTE;
          next_odd = ADDR[0];
          next_wd = (BYTE && ADDR[0]) ? {WDATA[7:0], 8'h00} : WDATA;
          next_busy = 1'b1;
          next_gnt = 1'b0;
        end
      end
      ipd_pkg::IPD_ADDR:
      begin
        next_st = ipd_pkg::IPD_DATA;
        next_aout = {6'h00, wd};
        next_aoe = wr;
        next_dstb = 1'b1;
        next_cnt = 12'h000;
      end
      ipd_pkg::IPD_DATA:
      begin
        if (BUS.reply || cnt == 12'(`IPD_TIMEOUT_CYC - 1))
        begin
          next_st = ipd_pkg::IPD_IDLE;
          next_aoe = 1'b0;
          next_dstb = 1'b0;
          next_sel_n = 1'b1;
          next_busy = 1'b0;
          next_done = BUS.reply;
          next_tmo = !BUS.reply;
          if (BUS.reply && !wr)
            next_rd = !bx ? rword : (odd ? {8'h00, rword[15:8]} : {8'h00, rword[7:0]});
        end
        else
          next_cnt = cnt + 12'h001;
      end
      default:
        next_st = ipd_pkg::IPD_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st <= ipd_pkg::IPD_IDLE;
      aout <= 22'h000000;
      aoe <= 1'b0;
      sel_n <= 1'b1;
      astb <= 1'b0;
      dstb <= 1'b0;
      wr <= 1'b0;
      bx <= 1'b0;
      odd <= 1'b0;
      wd <= 16'h0000;
      cnt <= 12'h000;
      busy <= 1'b0;
      done <= 1'b0;
      tmo <= 1'b0;
      rd <= 16'h0000;
      gnt <= 1'b0;
    end
    else
    begin
      st <= next_st;
      aout <= next_aout;
      aoe <= next_aoe;
      sel_n <= next_sel_n;
      astb <= next_astb;
      dstb <= next_dstb;
      wr <= next_wr;
      bx <= next_bx;
      odd <= next_odd;
      wd <= next_wd;
      cnt <= next_cnt;
      busy <= next_busy;
      done <= next_done;
      tmo <= next_tmo;
      rd <= next_rd;
      gnt <= next_gnt;
    end
  end

  assign BUS.mst_adl_out = aout;
  assign BUS.mst_adl_oe = aoe;
  assign BUS.io_page_select_n = sel_n;
  assign BUS.addr_strobe = astb;
  assign BUS.data_strobe = dstb;
  assign BUS.write = wr;
  assign BUS.byte_xfer = bx;
  assign BUS.grant = gnt;
  assign BUSY = busy;
  assign DONE = done;
  assign TIMEOUT = tmo;
  assign RDATA = rd;
endmodule : ipd_master

// File: sim/ipd_bus_monitor.sv
`include "ipd_cfg.svh"
module ipd_bus_monitor (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic [`IPD_AW-1:0] shared_addr_data_lines,
  input wire logic io_page_select_n,
  input wire logic addr_strobe,
  input wire logic data_strobe,
  input wire logic write,
  input wire logic reply,
  input wire logic dev_adl_oe,
  input wire logic mst_adl_oe,
  input wire logic bus_req,
  input wire logic grant,
  input wire logic grant_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  wire hit = addr_strobe && !io_page_select_n &&
             shared_addr_data_lines[15:3] == 13'(`IPD_BASE >> 3);
  page_in_top_a: assert property (addr_strobe && !io_page_select_n |->
    shared_addr_data_lines[15:13] == 3'h7) else $error("page select outside top page");
  match_reply_a: assert property (hit |-> ##2 reply)
    else $error("no reply to matched address");
  miss_quiet_a: assert property (addr_strobe && !hit |=> !reply [*4])
    else $error("reply to unmatched address");
  reply_pulse_a: assert property (reply |=> !reply && !data_strobe)
    else $error("reply or strobe held too long");
  read_drive_a: assert property (reply |-> dev_adl_oe == !write)
    else $error("device drive wrong for direction");
  addr_drive_a: assert property (addr_strobe |-> mst_adl_oe ##1 data_strobe)
    else $error("address phase malformed");
  grant_req_a: assert property (grant |-> $past(bus_req))
    else $error("grant without request");
  pass_on_a: assert property (grant_out |-> $past(grant))
    else $error("grant passed without grant");
  cover property (hit && write);
  cover property (hit && !write);
  cover property (grant);
endmodule : ipd_bus_monitor

// File: sim/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst_n = 0, start = 0, wr = 0, byt = 0, sreq = 0;
  logic [21:0] addr = '0;
  logic [15:0] wdata = '0, status = '0, rdata, ctrl, seen;
  logic [1:0] mode = '0;
  logic busy, done, tmo, granted, sel;
  logic [15:0] regs [4];
  int n_fail = 0, cmp_count = 0;
  always #2.5 clk = ~clk;
  ipd_bus_if bus ();
  ipd_master u_ipd_master (.CLK(clk), .RST_N(rst_n), .BUS(bus), .START(start), .ADDR(addr),
    .WRITE(wr), .BYTE(byt), .WDATA(wdata), .ADDR_MODE(mode), .BUSY(busy), .DONE(done),
    .TIMEOUT(tmo), .RDATA(rdata));
  ipd_device u_ipd_device (.CLK(clk), .RST_N(rst_n), .BUS(bus), .SERVICE_REQ(sreq),
    .STATUS_IN(status), .CTRL_OUT(ctrl), .SERVICE_GRANTED(granted), .SELECTED(sel));
  ipd_bus_monitor u_ipd_bus_monitor (.CLK(clk), .RST_N(rst_n),
    .shared_addr_data_lines(bus.shared_addr_data_lines), .io_page_select_n(bus.io_page_select_n),
    .addr_strobe(bus.addr_strobe), .data_strobe(bus.data_strobe), .write(bus.write),
    .reply(bus.reply), .dev_adl_oe(bus.dev_adl_oe), .mst_adl_oe(bus.mst_adl_oe),
    .bus_req(bus.bus_req), .grant(bus.grant), .grant_out(bus.grant_out));
  // Address seen on the shared lines in the address phase
  always @(negedge clk)
    if (bus.addr_strobe)
      seen = bus.shared_addr_data_lines[15:0];
  task automatic final_report();
    if (n_fail == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] d, logic b, logic odd);
    return !b ? d : odd ? {d[7:0], o[7:0]} : {o[15:8], d[7:0]};
  endfunction : merge
  function automatic logic [15:0] pick(logic [15:0] w, logic b, logic odd);
    return !b ? w : odd ? {8'h00, w[15:8]} : {8'h00, w[7:0]};
  endfunction : pick
  task automatic xfer(input logic [21:0] a, input logic w, b, input logic [15:0] d,
                      input logic [1:0] m, input logic miss);
    int n;
    logic [1:0] i;
    i = a[2:1];
    @(posedge clk);
    start <= 1'b1;
    addr <= a;
    wr <= w;
    byt <= b;
    wdata <= d;
    mode <= m;
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 2100 && done !== 1'b1 && tmo !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    chk({15'h0, tmo}, {15'h0, miss});
    chk({15'h0, busy}, 16'h0000);
    chk({15'h0, sel}, {15'h0, !miss});
    if (!miss)
    begin
      chk(16'(n), 16'h3);
      chk({seen[15:1], 1'b0}, {a[15:1], 1'b0});
      if (w && i != 2'h3)
        regs[i] = merge(regs[i], d, b, a[0]);
      if (!w)
        chk(rdata, pick(i == 2'h3 ? status : regs[i], b, a[0]));
    end
    chk(ctrl, regs[0]);
  endtask : xfer
  task automatic serve();
    int n;
    @(posedge clk);
    sreq <= 1'b1;
    for (n = 0; n < 20 && granted !== 1'b1; n++)
    begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    sreq <= 1'b0;
    repeat (6) @(posedge clk);
    chk(16'(n < 20), 16'h1);
  endtask : serve
  initial
  begin
    logic [1:0] m;
    logic [5:0] hi;
    logic [15:0] lo;
    void'($urandom(32'h80d215a4));
    regs = '{default: '0};
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int k = 0; k < 4; k++)
      xfer({6'h3f, 16'hff40 | 16'(k * 2)}, 1'b0, 1'b0, '0, 2'h2, 1'b0);
    xfer(22'h00ff40, 1'b0, 1'b0, '0, 2'h2, 1'b1);
    xfer(22'h3fff48, 1'b0, 1'b0, '0, 2'h2, 1'b1);
    xfer(22'h00ff42, 1'b1, 1'b0, 16'h1234, 2'h0, 1'b0);
    xfer(22'h00ff40, 1'b0, 1'b0, '0, 2'h1, 1'b1);
    xfer(22'h3fff45, 1'b1, 1'b1, 16'h00a5, 2'h3, 1'b0);
    xfer(22'h3fff44, 1'b0, 1'b0, '0, 2'h3, 1'b0);
    serve();
    repeat (60)
    begin
      m = 2'($urandom_range(2));
      hi = 6'($urandom);
      lo = 16'hff40 | 16'($urandom_range(7));
      @(posedge clk);
      status <= 16'($urandom);
      xfer(m == 2'h0 ? {hi, lo} : m == 2'h1 ? {hi[5:2], 2'h3, lo} : {6'h3f, lo},
           1'($urandom), 1'($urandom), 16'($urandom), m, 1'b0);
    end
    serve();
    final_report();
  end
  initial
  begin
    #100000;
    n_fail++;
    final_report();
  end
endmodule : tb_top
